/* File: hdl/board_led_jumper_status.sv */
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "board_defines.svh"
module board_led_jumper_status
   import board_types_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic option_strap_a,
   input wire logic option_strap_b,
   input wire logic option_strap_c,
   input wire logic option_strap_d,
   input wire logic option_strap_e,
   output logic red_lamp,
   output logic green_lamp
);

   // ----------------------------------------
   // decode and read data
   // ----------------------------------------
   function automatic reg_sel_t addr_decode(input logic [31:0] addr);
      reg_sel_t sel;
      sel = SEL_NONE;
      case (addr)
         `JUMPER_SENSE_ADDR: sel = SEL_JUMPER;
         `JUMPER_SIX_SENSE_ADDR: sel = SEL_JUMPER_SIX;
         `STATUS_LAMP_CONTROL_ADDR: sel = SEL_LAMP;
         default: sel = SEL_NONE;
      endcase
      return sel;
   endfunction

   function automatic logic [31:0] read_word(input reg_sel_t sel, input logic [4:0] fitted,
                                            input logic [7:0] lamp);
      logic [31:0] word;
      word = `READ_ZERO;
      case (sel)
         SEL_JUMPER: begin
            word[`SENSE_STRAP_A_BIT] = fitted[0];
            word[`SENSE_STRAP_B_BIT] = fitted[1];
            word[`SENSE_STRAP_C_BIT] = ~fitted[2];
            word[`SENSE_STRAP_D_BIT] = ~fitted[3];
         end
         SEL_JUMPER_SIX: begin
            word[`SENSE_STRAP_E_BIT] = fitted[4];
         end
         SEL_LAMP: begin
            word[7:0] = lamp;
         end
         default: begin
            word = `READ_ZERO;
         end
      endcase
      return word;
   endfunction

   // ----------------------------------------
   // strap synchronisers and lamp register
   // ----------------------------------------
   logic [4:0] strap_pins;
   logic [4:0] strap_fitted;
   logic [7:0] lamp_value;
   logic lamp_wr_en;

   assign strap_pins = {option_strap_e, option_strap_d, option_strap_c, option_strap_b,
                        option_strap_a};

   strap_sync #(.WIDTH(5)) u_strap_sync (
      .core_clk(core_clk),
      .nrst(nrst),
      .pin_in(strap_pins),
      .level(strap_fitted)
   );

   lamp_reg #(.WIDTH(8)) u_lamp_reg (
      .core_clk(core_clk),
      .nrst(nrst),
      .wr_en(lamp_wr_en),
      .wr_data(pwdata[7:0]),
      .value(lamp_value)
   );

   assign red_lamp = lamp_value[`LAMP_RED_BIT];
   assign green_lamp = lamp_value[`LAMP_GREEN_BIT];

   // ----------------------------------------
   // apb slave, one wait-free access phase
   // ----------------------------------------
   logic setup_phase;
   logic access_done;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   reg_sel_t cur_sel;

   always_comb begin
      cur_sel = addr_decode(paddr);
      setup_phase = psel && !penable;
      access_done = psel && penable && pready;
      // sense addresses ignore writes
      lamp_wr_en = access_done && pwrite && (cur_sel == SEL_LAMP) && pstrb[0];
      next_pready = setup_phase;
      next_pslverr = setup_phase && (cur_sel == SEL_NONE);
      next_prdata = prdata;
      if (setup_phase) begin
         next_prdata = pwrite ? `READ_ZERO : read_word(cur_sel, strap_fitted, lamp_value);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         prdata <= `READ_ZERO;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   sequence seq_read_setup(logic [31:0] addr);
      psel && !penable && !pwrite && (paddr == addr);
   endsequence

   sequence seq_access;
      psel && penable && pready;
   endsequence

   sequence seq_lamp_write;
      psel && penable && pready && pwrite && (paddr == `STATUS_LAMP_CONTROL_ADDR) && pstrb[0];
   endsequence

   a_lamps_at_reset: assert property (@(posedge core_clk)
      !nrst |=> (red_lamp && green_lamp))
      else $error("lamps not both lit after reset");

   a_red_write: assert property (@(posedge core_clk) disable iff (!nrst)
      (seq_access and (pwrite && paddr == `STATUS_LAMP_CONTROL_ADDR && pstrb[0]))
      |=> (red_lamp == $past(pwdata[`LAMP_RED_BIT])))
      else $error("red lamp does not follow bit 1");

   a_green_write: assert property (@(posedge core_clk) disable iff (!nrst)
      (seq_access and (pwrite && paddr == `STATUS_LAMP_CONTROL_ADDR && pstrb[0]))
      |=> (green_lamp == $past(pwdata[`LAMP_GREEN_BIT])))
      else $error("green lamp does not follow bit 0");

   a_jumper_read: assert property (@(posedge core_clk) disable iff (!nrst)
      seq_read_setup(`JUMPER_SENSE_ADDR) ##1 seq_access
      |-> (prdata[`SENSE_STRAP_A_BIT] == $past(strap_fitted[0])
           && prdata[`SENSE_STRAP_B_BIT] == $past(strap_fitted[1])))
      else $error("straps a or b misreported");

   a_inverted_read: assert property (@(posedge core_clk) disable iff (!nrst)
      seq_read_setup(`JUMPER_SENSE_ADDR) ##1 seq_access
      |-> (prdata[`SENSE_STRAP_C_BIT] != $past(strap_fitted[2])
           && prdata[`SENSE_STRAP_D_BIT] != $past(strap_fitted[3])))
      else $error("straps c or d not inverted");

   a_sense_zeros: assert property (@(posedge core_clk) disable iff (!nrst)
      seq_read_setup(`JUMPER_SENSE_ADDR) ##1 seq_access
      |-> (prdata[31:5] == 27'h0 && prdata[2] == 1'b0))
      else $error("unassigned jumper sense bits not zero");

   a_six_read: assert property (@(posedge core_clk) disable iff (!nrst)
      seq_read_setup(`JUMPER_SIX_SENSE_ADDR) ##1 seq_access
      |-> (prdata == {31'h0, $past(strap_fitted[4])}))
      else $error("strap e misreported");

   a_sense_write_void: assert property (@(posedge core_clk) disable iff (!nrst)
      (seq_access and (pwrite && paddr != `STATUS_LAMP_CONTROL_ADDR))
      |=> $stable(lamp_value))
      else $error("write elsewhere changed the lamps");

   a_ready_once: assert property (@(posedge core_clk) disable iff (!nrst)
      (psel && !penable) |=> (pready ##1 !pready))
      else $error("ready not a single cycle after setup");

   a_unmapped_err: assert property (@(posedge core_clk) disable iff (!nrst)
      (psel && !penable && addr_decode(paddr) == SEL_NONE) |=> (pslverr && pready))
      else $error("unmapped address gave no error");

   // ----------------------------------------
   // reset state
   // ----------------------------------------
   a_bus_reset: assert property (@(posedge core_clk)
      !nrst |=> (!pready && !pslverr && prdata == `READ_ZERO))
      else $error("bus outputs not cleared by reset");

   a_lamp_reg_reset: assert property (@(posedge core_clk)
      !nrst |=> (lamp_value == `LAMP_RESET))
      else $error("lamp register not preset by reset");

   a_strap_reset: assert property (@(posedge core_clk)
      !nrst |=> (strap_fitted == 5'h00))
      else $error("strap levels not cleared by reset");

   // ----------------------------------------
   // bus handshake
   // ----------------------------------------
   a_ready_needs_setup: assert property (@(posedge core_clk) disable iff (!nrst)
      !(psel && !penable) |=> !pready)
      else $error("ready raised without a setup cycle");

   a_err_needs_setup: assert property (@(posedge core_clk) disable iff (!nrst)
      !(psel && !penable) |=> !pslverr)
      else $error("error raised without a setup cycle");

   a_err_needs_ready: assert property (@(posedge core_clk) disable iff (!nrst)
      pslverr |-> pready)
      else $error("error shown without ready");

   a_mapped_no_err: assert property (@(posedge core_clk) disable iff (!nrst)
      (psel && !penable && addr_decode(paddr) != SEL_NONE) |=> (pready && !pslverr))
      else $error("mapped address answered with an error");

   a_unmapped_reads_zero: assert property (@(posedge core_clk) disable iff (!nrst)
      (psel && !penable && addr_decode(paddr) == SEL_NONE) |=> (prdata == `READ_ZERO))
      else $error("unmapped address returned nonzero data");

   a_write_reads_zero: assert property (@(posedge core_clk) disable iff (!nrst)
      (psel && !penable && pwrite) |=> (prdata == `READ_ZERO))
      else $error("write transfer returned nonzero data");

   a_prdata_hold: assert property (@(posedge core_clk) disable iff (!nrst)
      !(psel && !penable) |=> $stable(prdata))
      else $error("read data changed outside a setup cycle");

   a_ready_drops: assert property (@(posedge core_clk) disable iff (!nrst)
      pready |=> !pready)
      else $error("ready held for more than one cycle");

   a_sense_write_okay: assert property (@(posedge core_clk) disable iff (!nrst)
      (seq_access and (pwrite && (paddr == `JUMPER_SENSE_ADDR
                                  || paddr == `JUMPER_SIX_SENSE_ADDR)))
      |-> !pslverr)
      else $error("write to a sense address answered with an error");

   a_err_no_write: assert property (@(posedge core_clk) disable iff (!nrst)
      (seq_access and (pwrite && pslverr))
      |=> $stable(lamp_value))
      else $error("refused write changed the lamp register");

   // ----------------------------------------
   // lamp register
   // ----------------------------------------
   a_lamp_read: assert property (@(posedge core_clk) disable iff (!nrst)
      seq_read_setup(`STATUS_LAMP_CONTROL_ADDR) ##1 seq_access
      |-> (prdata == {24'h00_0000, $past(lamp_value)}))
      else $error("lamp register read back wrong");

   a_lamp_read_pins: assert property (@(posedge core_clk) disable iff (!nrst)
      seq_read_setup(`STATUS_LAMP_CONTROL_ADDR) ##1 seq_access
      |-> (prdata[`LAMP_RED_BIT] == red_lamp && prdata[`LAMP_GREEN_BIT] == green_lamp))
      else $error("lamp bits read back differ from the lamps");

   a_strobe_drop: assert property (@(posedge core_clk) disable iff (!nrst)
      (seq_access and (pwrite && paddr == `STATUS_LAMP_CONTROL_ADDR && !pstrb[0]))
      |=> $stable(lamp_value))
      else $error("lamp register written with byte 0 strobe low");

   a_lamp_quiet: assert property (@(posedge core_clk) disable iff (!nrst)
      !(psel && penable && pready && pwrite && paddr == `STATUS_LAMP_CONTROL_ADDR && pstrb[0])
      |=> $stable(lamp_value))
      else $error("lamp register changed without a lamp write");

   a_lamp_upper_store: assert property (@(posedge core_clk) disable iff (!nrst)
      seq_lamp_write |=> (lamp_value[7:2] == $past(pwdata[7:2])))
      else $error("upper lamp register bits not stored");

   a_six_keeps_lamps: assert property (@(posedge core_clk) disable iff (!nrst)
      (seq_access and (pwrite && paddr == `JUMPER_SIX_SENSE_ADDR))
      |=> ($stable(red_lamp) && $stable(green_lamp)))
      else $error("write to strap e address moved a lamp");

   // ----------------------------------------
   // strap sensing
   // ----------------------------------------
   a_strap_settle: assert property (@(posedge core_clk) disable iff (!nrst)
      ($past(nrst) && strap_pins == $past(strap_pins))
      |-> ##3 (strap_fitted == $past(strap_pins, 4)))
      else $error("steady strap pins not taken over in time");

   a_strap_b_read: assert property (@(posedge core_clk) disable iff (!nrst)
      seq_read_setup(`JUMPER_SENSE_ADDR) ##1 seq_access
      |-> (prdata[`SENSE_STRAP_B_BIT] == $past(strap_fitted[1])))
      else $error("strap b misreported");

   a_strap_c_read: assert property (@(posedge core_clk) disable iff (!nrst)
      seq_read_setup(`JUMPER_SENSE_ADDR) ##1 seq_access
      |-> (prdata[`SENSE_STRAP_C_BIT] == ~$past(strap_fitted[2])))
      else $error("strap c misreported");

   a_strap_d_read: assert property (@(posedge core_clk) disable iff (!nrst)
      seq_read_setup(`JUMPER_SENSE_ADDR) ##1 seq_access
      |-> (prdata[`SENSE_STRAP_D_BIT] == ~$past(strap_fitted[3])))
      else $error("strap d misreported");

   a_six_upper_zero: assert property (@(posedge core_clk) disable iff (!nrst)
      seq_read_setup(`JUMPER_SIX_SENSE_ADDR) ##1 seq_access
      |-> (prdata[31:1] == 31'h0000_0000))
      else $error("unassigned strap e bits not zero");

endmodule // board_led_jumper_status
`default_nettype wire

/* File: hdl/board_defines.svh */
// Summary of operation
// - lamp register bit 1 drives the red lamp, bit 0 the green lamp
// - both lamps light at reset, before any software write
// - straps a to d are readable at one jumper sense address
// - jumper sense bit 0 reads one when strap a is fitted
// - jumper sense bit 1 reads one when strap b is fitted
// - jumper sense bit 3 reads zero when strap c is fitted
// - jumper sense bit 4 reads zero when strap d is fitted
// - second sense address bit 0 reads one when strap e is fitted
`ifndef BOARD_DEFINES_SVH
`define BOARD_DEFINES_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define JUMPER_SENSE_ADDR 32'h1080_0000
`define JUMPER_SIX_SENSE_ADDR 32'h2280_0000
`define STATUS_LAMP_CONTROL_ADDR 32'h8084_0020

// ----------------------------------------
// field positions
// ----------------------------------------
`define LAMP_GREEN_BIT 0
`define LAMP_RED_BIT 1
`define SENSE_STRAP_A_BIT 0
`define SENSE_STRAP_B_BIT 1
`define SENSE_STRAP_C_BIT 3
`define SENSE_STRAP_D_BIT 4
`define SENSE_STRAP_E_BIT 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define LAMP_RESET 8'h03
`define READ_ZERO 32'h0000_0000

`endif

/* File: hdl/board_types_pkg.sv */
package board_types_pkg;

   // register selected by a bus address
   typedef enum logic [1:0] {
      SEL_NONE,
      SEL_JUMPER,
      SEL_JUMPER_SIX,
      SEL_LAMP
   } reg_sel_t;

endpackage : board_types_pkg

/* File: hdl/strap_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module strap_sync #(
   parameter int WIDTH = 5
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] level
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   logic [WIDTH-1:0] next_stage1;
   logic [WIDTH-1:0] next_stage2;
   logic [WIDTH-1:0] next_stage3;
   logic [WIDTH-1:0] next_level;

   // a bit changes only once the second and third stages agree
   always_comb begin
      next_stage1 = pin_in;
      next_stage2 = stage1;
      next_stage3 = stage2;
      next_level = (level & (stage2 ^ stage3)) | (stage3 & ~(stage2 ^ stage3));
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
         level <= '0;
      end else begin
         stage1 <= next_stage1;
         stage2 <= next_stage2;
         stage3 <= next_stage3;
         level <= next_level;
      end
   end

   a_sync_hold: assert property (@(posedge core_clk) disable iff (!nrst)
      (level != $past(level)) |-> ($past(stage2) == $past(stage3)))
      else $error("strap level changed while stages disagreed");

endmodule // strap_sync
`default_nettype wire

/* File: hdl/lamp_reg.sv */
`timescale 1ns/1ps
`default_nettype none
`include "board_defines.svh"
module lamp_reg #(
   parameter int WIDTH = 8
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic wr_en,
   input wire logic [WIDTH-1:0] wr_data,
   output logic [WIDTH-1:0] value
);

   logic [WIDTH-1:0] next_value;

   always_comb begin
      next_value = wr_en ? wr_data : value;
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         value <= WIDTH'(`LAMP_RESET);
      end else begin
         value <= next_value;
      end
   end

   a_lamp_store: assert property (@(posedge core_clk) disable iff (!nrst)
      wr_en |=> (value == $past(wr_data)))
      else $error("lamp register did not take written value");

   a_lamp_keep: assert property (@(posedge core_clk) disable iff (!nrst)
      !wr_en |=> $stable(value))
      else $error("lamp register changed without a write");

endmodule // lamp_reg
`default_nettype wire

/* File: dv/tb_board_led_jumper_status.sv */
`timescale 1ns/1ps
`default_nettype none
`include "board_defines.svh"
module tb_board_led_jumper_status;
   // ----------------------------------------
   // stimulus signals
   // ----------------------------------------
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0000_0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [4:0] strap = 5'h00;
   logic red_lamp;
   logic green_lamp;
   int errors = 0;
   int check_count = 0;

   board_led_jumper_status dut (
      .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .option_strap_a(strap[0]), .option_strap_b(strap[1]), .option_strap_c(strap[2]),
      .option_strap_d(strap[3]), .option_strap_e(strap[4]),
      .red_lamp(red_lamp), .green_lamp(green_lamp)
   );

   always #50 core_clk = ~core_clk;

   // ----------------------------------------
   // compare and bus tasks
   // ----------------------------------------
   task automatic chk32(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic chk1(input logic g, input logic e);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] rd, output logic er);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1);
      chk32(32'(n), 32'h0000_0001);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic exp_err);
      logic [31:0] rd;
      logic er;
      apb(1'b1, a, d, s, rd, er);
      chk1(er, exp_err);
   endtask

   task automatic rdc(input logic [31:0] a, input logic [31:0] e, input logic exp_err);
      logic [31:0] rd;
      logic er;
      apb(1'b0, a, 32'h0000_0000, 4'h0, rd, er);
      chk32(rd, e);
      chk1(er, exp_err);
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      chk1(red_lamp, 1'b1);
      chk1(green_lamp, 1'b1);
      rdc(`STATUS_LAMP_CONTROL_ADDR, 32'h0000_0003, 1'b0);
   endtask

   task automatic t_lamp();
      logic [1:0] seq [5] = '{2'h0, 2'h3, 2'h0, 2'h2, 2'h1};
      foreach (seq[i]) begin
         wr(`STATUS_LAMP_CONTROL_ADDR, {24'hFFFF_FF, 6'h29, seq[i]}, 4'hF, 1'b0);
         @(posedge core_clk);
         chk1(red_lamp, seq[i][1]);
         chk1(green_lamp, seq[i][0]);
         rdc(`STATUS_LAMP_CONTROL_ADDR, {24'h0, 6'h29, seq[i]}, 1'b0);
      end
      // byte 0 strobe low: write must be dropped
      wr(`STATUS_LAMP_CONTROL_ADDR, 32'h0000_0002, 4'hE, 1'b0);
      rdc(`STATUS_LAMP_CONTROL_ADDR, 32'h0000_00A5, 1'b0);
      chk1(red_lamp, 1'b0);
      chk1(green_lamp, 1'b1);
   endtask

   task automatic t_straps();
      logic [4:0] v;
      for (int i = 0; i < 32; i++) begin
         v = i[4:0];
         @(posedge core_clk);
         strap <= v;
         repeat (6) @(posedge core_clk);
         rdc(`JUMPER_SENSE_ADDR, {27'h0, ~v[3], ~v[2], 1'b0, v[1], v[0]}, 1'b0);
         rdc(`JUMPER_SIX_SENSE_ADDR, {31'h0, v[4]}, 1'b0);
      end
   endtask

   task automatic t_readonly();
      @(posedge core_clk);
      strap <= 5'h16;
      repeat (6) @(posedge core_clk);
      wr(`JUMPER_SENSE_ADDR, 32'hFFFF_FFFF, 4'hF, 1'b0);
      wr(`JUMPER_SIX_SENSE_ADDR, 32'hFFFF_FFFF, 4'hF, 1'b0);
      rdc(`JUMPER_SENSE_ADDR, 32'h0000_0012, 1'b0);
      rdc(`JUMPER_SIX_SENSE_ADDR, 32'h0000_0001, 1'b0);
      wr(32'h8084_0024, 32'h0000_0000, 4'hF, 1'b1);
      rdc(32'h8084_0024, 32'h0000_0000, 1'b1);
      rdc(`STATUS_LAMP_CONTROL_ADDR, 32'h0000_00A5, 1'b0);
   endtask

   // ----------------------------------------
   // run control
   // ----------------------------------------
   task automatic report_and_stop();
      $display("errors=%0d check_count=%0d", errors, check_count);
      if (errors == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      #(100 * 20000);
      errors++;
      report_and_stop();
   end

   initial begin
      repeat (10) @(posedge core_clk);
      chk1(red_lamp, 1'b1);
      chk1(green_lamp, 1'b1);
      nrst <= 1'b1;
      t_reset();
      t_lamp();
      t_straps();
      t_readonly();
      report_and_stop();
   end
endmodule // tb_board_led_jumper_status
`default_nettype wire
